// ===== rtl/dlb_bridge.sv
// Video bridge core: packet receiver, line buffer, flat-panel output.
// Assumes lanes are merged into one packet per cycle upstream and the
// serializer accepts pixels on i_lvds_ready at the pixel rate.
`timescale 1ns/1ns
module dlb_bridge #(
  parameter int DEPTH = 1024
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input dlb_pkg::dlb_pkt_t i_pkt_type,
  input wire logic [23:0] i_pkt_data,
  input wire logic i_dsi_ulps,
  input wire logic i_standby_pin_n,
  input wire logic i_ext_clk_run,
  input wire logic i_i2cs_sel,
  input wire logic i_i2cs_start,
  input wire logic i_i2cs_valid,
  input wire logic [7:0] i_i2cs_byte,
  output logic o_i2cs_ack,
  output logic [7:0] o_i2cs_rdata,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_lane0_oe,
  output logic [3:0] o_lane_en,
  input wire logic i_i2cm_ready,
  output logic o_i2cm_valid,
  output logic [7:0] o_i2cm_byte,
  input wire logic i_lvds_ready,
  output logic o_lvds_valid,
  output logic [23:0] o_lvds_a,
  output logic [23:0] o_lvds_b,
  output logic o_lvds_dual,
  output logic o_lvds_clk_inv,
  output logic o_pclk_from_dsi,
  output logic o_pll_en,
  output logic o_sleep,
  output logic o_standby,
  output logic o_power_down,
  output logic o_buf_ovf
);
  localparam int PW = dlb_pkg::PTR_W;
  localparam int AW = $clog2(DEPTH);

  // Expand any input format to 8 bits per colour
  function automatic logic [23:0] fmt_decode(
    input logic [23:0] d,
    input dlb_pkg::dlb_fmt_t f
  );
    logic [23:0] r;
    r = d;
    unique case (f)
      dlb_pkg::FMT_565:
        r = {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
      dlb_pkg::FMT_666P:
        r = {d[17:12], d[17:16], d[11:6], d[11:10], d[5:0], d[5:4]};
      dlb_pkg::FMT_666L:
        r = {d[23:18], d[23:22], d[15:10], d[15:14], d[7:2], d[7:6]};
      dlb_pkg::FMT_888:
        r = d;
    endcase
    return r;
  endfunction : fmt_decode

  // Reduce to 18 bits with optional dither, then reorder colours
  function automatic logic [23:0] pix_proc(
    input logic [23:0] p,
    input logic out24,
    input logic dith,
    input logic [1:0] map,
    input logic [1:0] thr
  );
    logic [8:0] s;
    logic [23:0] q;
    logic [23:0] m;
    s = 9'h000;
    q = p;
    if (!out24)
    begin
      for (int i = 0; i < 3; i++)
      begin
        s = {1'b0, p[i*8 +: 8]} + (dith ? {7'h00, thr} : 9'h000);
        q[i*8 +: 8] = s[8] ? 8'hFC : {s[7:2], 2'h0};
      end
    end
    unique case (map)
      2'h0: m = q;
      2'h1: m = {q[7:0], q[15:8], q[23:16]};
      2'h2: m = {q[15:8], q[7:0], q[23:16]};
      default: m = {q[23:16], q[7:0], q[15:8]};
    endcase
    return m;
  endfunction : pix_proc

  logic [7:0] ctrl_ff;
  logic [7:0] link_ff;
  logic [7:0] gaddr_ff;
  logic [7:0] i2cs_addr_ff;
  logic i2cs_rw_ff;
  dlb_pkg::dlb_i2cs_t i2cs_st_ff;
  dlb_pkg::dlb_i2cs_t nxt_i2cs_st;
  dlb_pkg::dlb_pwr_t pwr_ff;
  dlb_pkg::dlb_pwr_t nxt_pwr;
  logic [PW-1:0] wptr_ff;
  logic [PW-1:0] rptr_ff;
  logic [23:0] mem [DEPTH];
  logic half_ff;
  logic [23:0] hold_ff;
  logic x_ff;
  logic frame_ff;

  dlb_stream_if #(.W(24)) buf_in ();
  dlb_stream_if #(.W(24)) buf_out ();

  // Packet decode
  wire pk_fsync = (i_pkt_type == dlb_pkg::PKT_FSYNC);
  wire pk_pixel = (i_pkt_type == dlb_pkg::PKT_PIXEL);
  wire pk_gwa = (i_pkt_type == dlb_pkg::PKT_GWR_ADDR);
  wire pk_gwd = (i_pkt_type == dlb_pkg::PKT_GWR_DATA);
  wire pk_grd = (i_pkt_type == dlb_pkg::PKT_GRD);

  // Configuration fields
  wire cf_dual = ctrl_ff[dlb_pkg::CTRL_DUAL];
  wire cf_out24 = ctrl_ff[dlb_pkg::CTRL_OUT24];
  wire cf_dith = ctrl_ff[dlb_pkg::CTRL_DITH];
  wire [1:0] cf_lanes = link_ff[dlb_pkg::LINK_LANE_LO +: 2];
  wire [1:0] cf_map = link_ff[dlb_pkg::LINK_MAP_LO +: 2];
  wire dlb_pkg::dlb_fmt_t cf_fmt =
    dlb_pkg::dlb_fmt_t'(ctrl_ff[dlb_pkg::CTRL_FMT_LO +: 2]);

  // Power state flags
  wire run = (pwr_ff == dlb_pkg::PWR_RUN);
  wire flush = !run;
  assign o_sleep = (pwr_ff == dlb_pkg::PWR_SLEEP);
  assign o_standby = (pwr_ff == dlb_pkg::PWR_STANDBY_PIN);
  assign o_pll_en = !o_sleep && !o_standby;
  assign o_power_down = !i_rst_n && !i_ext_clk_run &&
    !i_standby_pin_n && i_dsi_ulps;

  // Status register image
  wire [7:0] stat = {4'h0, o_buf_ovf, o_standby, o_sleep, o_i2cm_valid};

  // Register read decode, shared by both access paths
  function automatic logic [7:0] rd_reg(
    input logic [7:0] a,
    input logic [7:0] c,
    input logic [7:0] l,
    input logic [7:0] i,
    input logic [7:0] s
  );
    logic [7:0] r;
    r = 8'h00;
    if (a == dlb_pkg::REG_CTRL)
      r = c;
    else if (a == dlb_pkg::REG_LINK)
      r = l;
    else if (a == dlb_pkg::REG_I2CM)
      r = i;
    else if (a == dlb_pkg::REG_STAT)
      r = s;
    return r;
  endfunction : rd_reg

  // Shared register write port, link packets first
  wire i2cs_wr = i_i2cs_valid && !i_i2cs_start && !i2cs_rw_ff &&
    (i2cs_st_ff == dlb_pkg::I2CS_DAT);
  wire wr_en = pk_gwd || i2cs_wr;
  wire [7:0] wr_addr = pk_gwd ? gaddr_ff : i2cs_addr_ff;
  wire [7:0] wr_data = pk_gwd ? i_pkt_data[7:0] : i_i2cs_byte;
  wire i2cm_wr = wr_en && (wr_addr == dlb_pkg::REG_I2CM);
  wire i2cm_go = i2cm_wr && !i_i2cs_sel && !o_i2cm_valid;

  // Configuration registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_ff <= dlb_pkg::CTRL_RST;
      link_ff <= dlb_pkg::LINK_RST;
    end
    else if (i_ce && wr_en)
    begin
      if (wr_addr == dlb_pkg::REG_CTRL)
        ctrl_ff <= wr_data;
      if (wr_addr == dlb_pkg::REG_LINK)
        link_ff <= wr_data;
    end
  end

  // Generic packets: address, data with increment, read reply
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      gaddr_ff <= 8'h00;
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
    end
    else if (i_ce)
    begin
      if (pk_gwa)
        gaddr_ff <= i_pkt_data[7:0];
      else if (pk_gwd)
        gaddr_ff <= gaddr_ff + 8'h01;
      o_rd_valid <= pk_grd;
      if (pk_grd)
        o_rd_data <= rd_reg(i_pkt_data[7:0], ctrl_ff, link_ff,
          o_i2cm_byte, stat);
    end
  end

  // Lane 0 drives only while a read reply is out
  assign o_lane0_oe = o_rd_valid;

  // Lane enables, thermometer of configured count
  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    assign o_lane_en[g] = (cf_lanes >= 2'(g));
  end

  // Clock routing controls
  assign o_pclk_from_dsi = ctrl_ff[dlb_pkg::CTRL_PCLK_DSI];
  assign o_lvds_clk_inv = ctrl_ff[dlb_pkg::CTRL_CKPOL];
  assign o_lvds_dual = cf_dual;

  // I2C master command byte, held until taken or the slave is selected
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_i2cm_valid <= 1'b0;
      o_i2cm_byte <= 8'h00;
    end
    else if (i_ce)
    begin
      if (i2cm_go)
      begin
        o_i2cm_valid <= 1'b1;
        o_i2cm_byte <= wr_data;
      end
      else if (i_i2cm_ready || i_i2cs_sel)
        o_i2cm_valid <= 1'b0;
    end
  end

  // Slave byte sequencer: address, register, data
  wire i2cs_hit = (i_i2cs_byte[7:1] == dlb_pkg::I2CS_ADDR);
  always_comb
  begin
    nxt_i2cs_st = i2cs_st_ff;
    if (i_i2cs_start)
      nxt_i2cs_st = dlb_pkg::I2CS_ADR;
    else if (i_i2cs_valid)
    begin
      unique case (i2cs_st_ff)
        dlb_pkg::I2CS_ADR:
          if (!i2cs_hit)
            nxt_i2cs_st = dlb_pkg::I2CS_IGN;
          else if (i_i2cs_byte[0])
            nxt_i2cs_st = dlb_pkg::I2CS_DAT;
          else
            nxt_i2cs_st = dlb_pkg::I2CS_REG;
        dlb_pkg::I2CS_REG:
          nxt_i2cs_st = dlb_pkg::I2CS_DAT;
        dlb_pkg::I2CS_DAT:
          nxt_i2cs_st = dlb_pkg::I2CS_DAT;
        dlb_pkg::I2CS_IGN:
          nxt_i2cs_st = dlb_pkg::I2CS_IGN;
      endcase
    end
  end

  wire i2cs_take = i_i2cs_valid && !i_i2cs_start &&
    (i2cs_st_ff != dlb_pkg::I2CS_IGN) &&
    (i2cs_st_ff != dlb_pkg::I2CS_ADR || i2cs_hit);

  // Slave address pointer, direction and answers
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      i2cs_st_ff <= dlb_pkg::I2CS_IGN;
      i2cs_rw_ff <= 1'b0;
      i2cs_addr_ff <= 8'h00;
      o_i2cs_ack <= 1'b0;
      o_i2cs_rdata <= 8'h00;
    end
    else if (i_ce)
    begin
      i2cs_st_ff <= nxt_i2cs_st;
      o_i2cs_ack <= i2cs_take;
      o_i2cs_rdata <= rd_reg(i2cs_addr_ff, ctrl_ff, link_ff,
        o_i2cm_byte, stat);
      if (i2cs_take && i2cs_st_ff == dlb_pkg::I2CS_ADR)
        i2cs_rw_ff <= i_i2cs_byte[0];
      else if (i2cs_take && i2cs_st_ff == dlb_pkg::I2CS_REG)
        i2cs_addr_ff <= i_i2cs_byte;
      else if (i2cs_take && i2cs_st_ff == dlb_pkg::I2CS_DAT)
        i2cs_addr_ff <= i2cs_addr_ff + 8'h01;
    end
  end

  // Power state: standby over sleep, wake waits for frame sync
  always_comb
  begin
    nxt_pwr = pwr_ff;
    if (!i_standby_pin_n)
      nxt_pwr = dlb_pkg::PWR_STANDBY_PIN;
    else if (i_dsi_ulps)
      nxt_pwr = dlb_pkg::PWR_SLEEP;
    else if (pwr_ff != dlb_pkg::PWR_RUN && pk_fsync)
      nxt_pwr = dlb_pkg::PWR_RUN;
    else if (pwr_ff != dlb_pkg::PWR_RUN)
      nxt_pwr = dlb_pkg::PWR_WAIT;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pwr_ff <= dlb_pkg::PWR_WAIT;
    else if (i_ce)
      pwr_ff <= nxt_pwr;
  end

  // Line buffer occupancy
  wire [PW-1:0] used = wptr_ff - rptr_ff;
  wire buf_full = (used == PW'(DEPTH));
  wire buf_empty = (used == '0);
  wire pix_wr = run && pk_pixel && !buf_full;
  wire pix_ovf = run && pk_pixel && buf_full;

  // Pixel store, no reset needed
  always_ff @(posedge i_clk_sys)
  begin
    if (i_ce && pix_wr)
      mem[wptr_ff[AW-1:0]] <= fmt_decode(i_pkt_data, cf_fmt);
  end

  // Pointers flushed outside run; overflow flag cleared by frame sync
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      o_buf_ovf <= 1'b0;
    end
    else if (i_ce)
    begin
      if (flush)
      begin
        wptr_ff <= '0;
        rptr_ff <= '0;
      end
      else
      begin
        if (pix_wr)
          wptr_ff <= wptr_ff + PW'(1);
        if (buf_in.valid && buf_in.ready)
          rptr_ff <= rptr_ff + PW'(1);
      end
      if (pix_ovf)
        o_buf_ovf <= 1'b1;
      else if (pk_fsync)
        o_buf_ovf <= 1'b0;
    end
  end

  // Buffer head into the two-entry stage
  assign buf_in.valid = run && !buf_empty;
  assign buf_in.data = mem[rptr_ff[AW-1:0]];

  dlb_skid2 #(.W(24)) u_skid (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_flush(flush),
    .s(buf_in),
    .m(buf_out)
  );

  // Output stage: pairs pixels in dual link
  wire out_free = !o_lvds_valid || i_lvds_ready;
  assign buf_out.ready = run && out_free;
  wire take = buf_out.valid && buf_out.ready;
  wire emit = take && (!cf_dual || half_ff);
  wire [23:0] pix = pix_proc(buf_out.data, cf_out24, cf_dith,
    cf_map, {x_ff ^ frame_ff, x_ff});

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_lvds_valid <= 1'b0;
      o_lvds_a <= 24'h000000;
      o_lvds_b <= 24'h000000;
      half_ff <= 1'b0;
      hold_ff <= 24'h000000;
      x_ff <= 1'b0;
      frame_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      if (pk_fsync)
        frame_ff <= !frame_ff;
      if (flush)
      begin
        o_lvds_valid <= 1'b0;
        half_ff <= 1'b0;
        x_ff <= 1'b0;
      end
      else
      begin
        o_lvds_valid <= emit || (o_lvds_valid && !i_lvds_ready);
        if (take)
        begin
          x_ff <= !x_ff;
          half_ff <= cf_dual && !half_ff;
          hold_ff <= pix;
        end
        if (emit)
        begin
          o_lvds_a <= cf_dual ? hold_ff : pix;
          o_lvds_b <= cf_dual ? pix : 24'h000000;
        end
      end
    end
  end
endmodule : dlb_bridge

// ===== rtl/dlb_pkg.sv
// Shared constants and types of the video bridge core.
// Assumes one system clock; all other sides are abstracted as ports.
package dlb_pkg;
  // Datapath sizes
  localparam int PIX_W = 24;
  localparam int BUF_DEPTH = 1024;
  localparam int PTR_W = 11;

  // Link limits, for reference by integrators
  localparam int LANE_MAX_MBPS = 1000;
  localparam int PCLK_MAX_MHZ = 135;
  localparam int PCLK_DUAL_MAX_MHZ = 270;

  // Register addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LINK = 8'h01;
  localparam logic [7:0] REG_I2CM = 8'h02;
  localparam logic [7:0] REG_STAT = 8'h03;

  // Control register fields
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_OUT24 = 1;
  localparam int CTRL_DITH = 2;
  localparam int CTRL_CKPOL = 3;
  localparam int CTRL_PCLK_DSI = 4;
  localparam int CTRL_FMT_LO = 5;

  // Link register fields
  localparam int LINK_LANE_LO = 0;
  localparam int LINK_MAP_LO = 2;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h62;
  localparam logic [7:0] LINK_RST = 8'h03;

  // Configuration slave address
  localparam logic [6:0] I2CS_ADDR = 7'h0F;

  typedef enum logic [2:0]
  {
    PKT_NONE, PKT_FSYNC, PKT_LSYNC, PKT_PIXEL,
    PKT_GWR_ADDR, PKT_GWR_DATA, PKT_GRD
  } dlb_pkt_t;

  typedef enum logic [1:0] {FMT_565, FMT_666P, FMT_666L, FMT_888} dlb_fmt_t;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_STANDBY_PIN, PWR_WAIT} dlb_pwr_t;

  typedef enum logic [1:0] {I2CS_ADR, I2CS_REG, I2CS_DAT, I2CS_IGN} dlb_i2cs_t;
endpackage : dlb_pkg

// ===== rtl/dlb_skid2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock, a clock enable and a synchronous flush.
`timescale 1ns/1ns
module dlb_skid2 #(
  parameter int W = 24
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_flush,
  dlb_stream_if.snk s,
  dlb_stream_if.src m
);
  logic [1:0] cnt_ff;
  logic [W-1:0] ent0_ff;
  logic [W-1:0] ent1_ff;
  wire push = s.valid && s.ready;
  wire pop = m.valid && m.ready;

  // Handshake and head word
  assign s.ready = (cnt_ff != 2'h2);
  assign m.valid = (cnt_ff != 2'h0);
  assign m.data = ent0_ff;

  // Occupancy count
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_ff <= 2'h0;
    else if (i_ce)
    begin
      if (i_flush)
        cnt_ff <= 2'h0;
      else if (push && !pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end

  // Entry storage, head in entry 0
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ent0_ff <= '0;
      ent1_ff <= '0;
    end
    else if (i_ce && !i_flush)
    begin
      if (pop)
        ent0_ff <= (cnt_ff == 2'h2) ? ent1_ff : s.data;
      else if (push && cnt_ff == 2'h0)
        ent0_ff <= s.data;
      if (push && (cnt_ff == 2'h2 || (cnt_ff == 2'h1 && !pop)))
        ent1_ff <= s.data;
    end
  end
endmodule : dlb_skid2

// ===== rtl/dlb_stream_if.sv
// Valid/ready pixel stream between the bridge's own modules.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface dlb_stream_if #(parameter int W = 24);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dlb_stream_if

// ===== tb/dlb_bridge_sva.sv
// Checker of the bridge's port timing, bound to the top module.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ns
module dlb_bridge_sva #(
  parameter int DEPTH = 1024
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input dlb_pkg::dlb_pkt_t i_pkt_type,
  input wire logic i_dsi_ulps,
  input wire logic i_standby_pin_n,
  input wire logic i_i2cs_valid,
  input wire logic i_i2cs_sel,
  input wire logic i_i2cm_ready,
  input wire logic i_lvds_ready,
  input wire logic o_i2cs_ack,
  input wire logic o_rd_valid,
  input wire logic o_lane0_oe,
  input wire logic [3:0] o_lane_en,
  input wire logic o_i2cm_valid,
  input wire logic [7:0] o_i2cm_byte,
  input wire logic o_lvds_valid,
  input wire logic [23:0] o_lvds_a,
  input wire logic [23:0] o_lvds_b,
  input wire logic o_pll_en,
  input wire logic o_sleep,
  input wire logic o_standby
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Register access, lane use and clocking
  a_rd_reply: assert property (i_ce && i_pkt_type == dlb_pkg::PKT_GRD |=> o_rd_valid)
    else $error("read reply missing");
  a_lane0_dir: assert property (o_lane0_oe == o_rd_valid)
    else $error("lane 0 drives outside a reply");
  a_lane_therm: assert property (o_lane_en inside {4'h1, 4'h3, 4'h7, 4'hF})
    else $error("lane enables not contiguous");
  a_pll_use: assert property (o_pll_en == !(o_sleep || o_standby))
    else $error("bit clock enable wrong");
  // Power states
  a_standby_pin_enter: assert property (i_ce && !i_standby_pin_n |=> o_standby)
    else $error("standby not entered");
  a_sleep_enter: assert property (i_ce && i_dsi_ulps && i_standby_pin_n |=> o_sleep)
    else $error("sleep not entered");
  a_lowpwr_idle: assert property ((o_sleep && $past(o_sleep)) || (o_standby && $past(o_standby)) |-> !o_lvds_valid)
    else $error("output active in low power");
  // Output beats and master commands hold until taken, master lockout, slave ack
  a_lvds_hold: assert property (o_lvds_valid && !i_lvds_ready && i_ce && !i_dsi_ulps && i_standby_pin_n |=> o_lvds_valid && $stable(o_lvds_a) && $stable(o_lvds_b))
    else $error("output beat changed before taken");
  a_i2cm_hold: assert property (o_i2cm_valid && !i_i2cm_ready && !i_i2cs_sel && i_ce |=> o_i2cm_valid && $stable(o_i2cm_byte))
    else $error("master command dropped");
  a_i2cm_off: assert property (i_ce && i_i2cs_sel |=> !o_i2cm_valid)
    else $error("master active with slave config");
  a_i2cs_ack: assert property (o_i2cs_ack |-> $past(i_i2cs_valid))
    else $error("slave ack without a byte");
endmodule : dlb_bridge_sva

bind dlb_bridge dlb_bridge_sva #(.DEPTH(DEPTH)) u_dlb_bridge_sva (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_pkt_type(i_pkt_type), .i_dsi_ulps(i_dsi_ulps),
  .i_standby_pin_n(i_standby_pin_n), .i_i2cs_valid(i_i2cs_valid),
  .i_i2cs_sel(i_i2cs_sel), .i_i2cm_ready(i_i2cm_ready),
  .i_lvds_ready(i_lvds_ready), .o_i2cs_ack(o_i2cs_ack),
  .o_rd_valid(o_rd_valid), .o_lane0_oe(o_lane0_oe), .o_lane_en(o_lane_en),
  .o_i2cm_valid(o_i2cm_valid), .o_i2cm_byte(o_i2cm_byte),
  .o_lvds_valid(o_lvds_valid), .o_lvds_a(o_lvds_a), .o_lvds_b(o_lvds_b),
  .o_pll_en(o_pll_en), .o_sleep(o_sleep), .o_standby(o_standby));

// ===== tb/dlb_host_model.sv
// Host-side model: sends sync, pixel and generic packets.
// Assumes each task is entered just after a falling clock edge.
`timescale 1ns/1ns
module dlb_host_model (
  input wire logic i_clk_sys,
  output dlb_pkg::dlb_pkt_t o_pkt_type,
  output logic [23:0] o_pkt_data,
  output logic o_dsi_ulps
);
  // Idle link after power-up
  initial
  begin
    o_pkt_type = dlb_pkg::PKT_NONE;
    o_pkt_data = 24'h000000;
    o_dsi_ulps = 1'b0;
  end
  // One packet for one clock
  task automatic pkt(input dlb_pkg::dlb_pkt_t t, input logic [23:0] d);
    o_pkt_type = t;
    o_pkt_data = d;
    @(negedge i_clk_sys);
  endtask : pkt
  // No packet; payload inverted so no stale value looks meaningful
  task automatic idle();
    o_pkt_type = dlb_pkg::PKT_NONE;
    o_pkt_data = ~o_pkt_data;
    @(negedge i_clk_sys);
  endtask : idle
  // Frame and line sync, then pixels spaced by gap idle cycles
  task automatic frame(input logic [23:0] b, input int n, input int gap);
    pkt(dlb_pkg::PKT_FSYNC, 24'h000000);
    pkt(dlb_pkg::PKT_LSYNC, 24'h000000);
    for (int k = 0; k < n; k++)
    begin
      pkt(dlb_pkg::PKT_PIXEL, b + 24'(k));
      repeat (gap) idle();
    end
    idle();
  endtask : frame
  // Ultra-low-power signalling of the link
  task automatic ulps(input logic on);
    o_dsi_ulps = on;
    @(negedge i_clk_sys);
  endtask : ulps
endmodule : dlb_host_model

// ===== tb/tb_dlb_bridge.sv
// Testbench of the video bridge: register, video, I2C and power tests.
// Assumes the host model sends packets and the bench is the serializer.
`timescale 1ns/1ns
module tb_dlb_bridge;
  logic i_clk_sys, i_rst_n, i_ce, i_standby_pin_n, i_ext_clk_run;
  logic i_i2cs_sel, i_i2cs_start, i_i2cs_valid, i_i2cm_ready, i_lvds_ready;
  logic [7:0] i_i2cs_byte;
  dlb_pkg::dlb_pkt_t i_pkt_type;
  logic [23:0] i_pkt_data;
  logic i_dsi_ulps;
  logic o_i2cs_ack, o_rd_valid, o_lane0_oe, o_i2cm_valid, o_lvds_valid;
  logic o_lvds_dual, o_lvds_clk_inv, o_pclk_from_dsi, o_pll_en, o_sleep;
  logic o_standby, o_power_down, o_buf_ovf;
  logic [7:0] o_i2cs_rdata, o_rd_data, o_i2cm_byte;
  logic [3:0] o_lane_en;
  logic [23:0] o_lvds_a, o_lvds_b;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  dlb_bridge #(.DEPTH(4)) u_dlb_bridge (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_pkt_type(i_pkt_type), .i_pkt_data(i_pkt_data),
    .i_dsi_ulps(i_dsi_ulps), .i_standby_pin_n(i_standby_pin_n),
    .i_ext_clk_run(i_ext_clk_run), .i_i2cs_sel(i_i2cs_sel),
    .i_i2cs_start(i_i2cs_start), .i_i2cs_valid(i_i2cs_valid),
    .i_i2cs_byte(i_i2cs_byte), .o_i2cs_ack(o_i2cs_ack),
    .o_i2cs_rdata(o_i2cs_rdata), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_lane0_oe(o_lane0_oe), .o_lane_en(o_lane_en),
    .i_i2cm_ready(i_i2cm_ready), .o_i2cm_valid(o_i2cm_valid),
    .o_i2cm_byte(o_i2cm_byte), .i_lvds_ready(i_lvds_ready),
    .o_lvds_valid(o_lvds_valid), .o_lvds_a(o_lvds_a), .o_lvds_b(o_lvds_b),
    .o_lvds_dual(o_lvds_dual), .o_lvds_clk_inv(o_lvds_clk_inv),
    .o_pclk_from_dsi(o_pclk_from_dsi), .o_pll_en(o_pll_en),
    .o_sleep(o_sleep), .o_standby(o_standby),
    .o_power_down(o_power_down), .o_buf_ovf(o_buf_ovf));
  dlb_host_model u_dlb_host_model (.i_clk_sys(i_clk_sys),
    .o_pkt_type(i_pkt_type), .o_pkt_data(i_pkt_data),
    .o_dsi_ulps(i_dsi_ulps));

  // System clock, 10 ns period
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard, well above the expected run length
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Generic write of one byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_dlb_host_model.pkt(dlb_pkg::PKT_GWR_ADDR, {16'h0000, a});
    u_dlb_host_model.pkt(dlb_pkg::PKT_GWR_DATA, {16'h0000, d});
    u_dlb_host_model.idle();
  endtask : wr
  // Generic read; the reply stands for the cycle after the request
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_dlb_host_model.pkt(dlb_pkg::PKT_GRD, {16'h0000, a});
    chk("rd_valid", 24'h000001, o_rd_valid);
    chk("lane0_oe", 24'h000001, o_lane0_oe);
    chk("rd_data", {16'h0000, e}, o_rd_data);
    u_dlb_host_model.idle();
  endtask : rd
  // Serializer side: wait for a beat, compare, accept it
  task automatic take(input logic [23:0] ea, input logic [23:0] eb);
    int n;
    n = 0;
    while (o_lvds_valid !== 1'b1 && n < 30)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    chk("lvds_valid", 24'h000001, o_lvds_valid);
    chk("lvds_a", ea, o_lvds_a);
    chk("lvds_b", eb, o_lvds_b);
    i_lvds_ready = 1'b1;
    @(negedge i_clk_sys);
    i_lvds_ready = 1'b0;
    @(negedge i_clk_sys);
  endtask : take
  // One byte from the I2C slave front end, optionally after a start
  task automatic i2c(input logic s, input logic [7:0] b, input logic ea);
    i_i2cs_start = s;
    @(negedge i_clk_sys);
    i_i2cs_start = 1'b0;
    i_i2cs_valid = 1'b1;
    i_i2cs_byte = b;
    @(negedge i_clk_sys);
    i_i2cs_valid = 1'b0;
    i_i2cs_byte = ~b;
    chk("i2cs_ack", {23'h0, ea}, o_i2cs_ack);
    @(negedge i_clk_sys);
  endtask : i2c

  task automatic test_done();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_standby_pin_n = 1'b1;
    i_ext_clk_run = 1'b1;
    i_i2cs_sel = 1'b0;
    i_i2cs_start = 1'b0;
    i_i2cs_valid = 1'b0;
    i_i2cs_byte = 8'h00;
    i_i2cm_ready = 1'b0;
    i_lvds_ready = 1'b0;
    repeat (16) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    chk("lane_en", 24'h00000F, o_lane_en);
    chk("pll_en", 24'h000001, o_pll_en);
    rd(dlb_pkg::REG_CTRL, dlb_pkg::CTRL_RST);
    rd(dlb_pkg::REG_LINK, dlb_pkg::LINK_RST);
    for (int i = 0; i < 4; i++)
    begin
      wr(dlb_pkg::REG_LINK, 8'(i));
      chk("lane_en", 24'((1 << (i + 1)) - 1), o_lane_en);
    end
    u_dlb_host_model.pkt(dlb_pkg::PKT_GWR_ADDR, 24'h000000);
    u_dlb_host_model.pkt(dlb_pkg::PKT_GWR_DATA, 24'h000079);
    u_dlb_host_model.pkt(dlb_pkg::PKT_GWR_DATA, 24'h000007);
    u_dlb_host_model.idle();
    chk("lvds_dual", 24'h000001, o_lvds_dual);
    chk("clk_inv", 24'h000001, o_lvds_clk_inv);
    chk("pclk_dsi", 24'h000001, o_pclk_from_dsi);
    rd(dlb_pkg::REG_LINK, 8'h07);
    wr(dlb_pkg::REG_STAT, 8'hFF);
    rd(dlb_pkg::REG_STAT, 8'h00);
    rd(8'h10, 8'h00);
    $display("test registers done");
    // Remapped colour order, blue and red swapped
    wr(dlb_pkg::REG_CTRL, 8'h62);
    u_dlb_host_model.frame(24'hA1B2C3, 1, 3);
    take(24'hC3B2A1, 24'h000000);
    wr(dlb_pkg::REG_LINK, 8'h03);
    u_dlb_host_model.frame(24'h123456, 2, 0);
    take(24'h123456, 24'h000000);
    take(24'h123457, 24'h000000);
    for (int f = 0; f < 4; f++)
    begin
      wr(dlb_pkg::REG_CTRL, {1'b0, 2'(f), 5'h02});
      u_dlb_host_model.frame(24'h000001, 1, 0);
      take(f == 3 ? 24'h1 : 24'h8 >> (f * f), 24'h0);
    end
    wr(dlb_pkg::REG_CTRL, 8'h64);
    u_dlb_host_model.frame(24'h4181C3, 1, 0);
    take(24'h4080C4, 24'h000000);
    wr(dlb_pkg::REG_CTRL, 8'h63);
    u_dlb_host_model.frame(24'h000010, 2, 0);
    take(24'h000010, 24'h000011);
    wr(dlb_pkg::REG_CTRL, 8'h62);
    $display("test video done");
    // Serializer stalls while more pixels arrive than fit
    u_dlb_host_model.frame(24'h000100, 12, 0);
    chk("buf_ovf", 24'h000001, o_buf_ovf);
    for (int k = 0; k < 4; k++)
      take(24'h000100 + 24'(k), 24'h000000);
    i_lvds_ready = 1'b1;
    repeat (10) @(negedge i_clk_sys);
    i_lvds_ready = 1'b0;
    u_dlb_host_model.frame(24'h000000, 0, 0);
    chk("buf_ovf", 24'h000000, o_buf_ovf);
    $display("test stall done");
    // Sleep flushes; streaming resumes only after a frame sync
    u_dlb_host_model.frame(24'h000200, 1, 0);
    u_dlb_host_model.ulps(1'b1);
    u_dlb_host_model.pkt(dlb_pkg::PKT_PIXEL, 24'h000201);
    u_dlb_host_model.idle();
    chk("sleep", 24'h000001, o_sleep);
    chk("pll_en", 24'h000000, o_pll_en);
    chk("lvds_valid", 24'h000000, o_lvds_valid);
    u_dlb_host_model.ulps(1'b0);
    u_dlb_host_model.pkt(dlb_pkg::PKT_PIXEL, 24'h000300);
    repeat (10) u_dlb_host_model.idle();
    chk("lvds_valid", 24'h000000, o_lvds_valid);
    u_dlb_host_model.frame(24'h000400, 1, 0);
    take(24'h000400, 24'h000000);
    i_standby_pin_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk("standby", 24'h000001, o_standby);
    chk("pll_en", 24'h000000, o_pll_en);
    i_standby_pin_n = 1'b1;
    u_dlb_host_model.frame(24'h000500, 1, 0);
    take(24'h000500, 24'h000000);
    $display("test power states done");
    // I2C slave configuration and master lockout
    i2c(1'b1, 8'h1E, 1'b1);
    i2c(1'b0, 8'h01, 1'b1);
    i2c(1'b0, 8'h0C, 1'b1);
    rd(dlb_pkg::REG_LINK, 8'h0C);
    i2c(1'b1, 8'h20, 1'b0);
    i2c(1'b0, 8'h01, 1'b0);
    i_i2cs_sel = 1'b1;
    wr(dlb_pkg::REG_I2CM, 8'hA5);
    chk("i2cm_valid", 24'h000000, o_i2cm_valid);
    i_i2cs_sel = 1'b0;
    wr(dlb_pkg::REG_I2CM, 8'h5A);
    repeat (3) @(negedge i_clk_sys);
    chk("i2cm_valid", 24'h000001, o_i2cm_valid);
    chk("i2cm_byte", 24'h00005A, o_i2cm_byte);
    chk("i2cs_rdata", 24'h00005A, o_i2cs_rdata);
    i_i2cm_ready = 1'b1;
    @(negedge i_clk_sys);
    i_i2cm_ready = 1'b0;
    @(negedge i_clk_sys);
    chk("i2cm_valid", 24'h000000, o_i2cm_valid);
    $display("test i2c done");
    // Lowest power needs all four conditions together
    i_rst_n = 1'b0;
    i_ext_clk_run = 1'b0;
    i_standby_pin_n = 1'b0;
    u_dlb_host_model.ulps(1'b1);
    chk("power_down", 24'h000001, o_power_down);
    i_ext_clk_run = 1'b1;
    #1;
    chk("power_down", 24'h000000, o_power_down);
    $display("test power down done");
    test_done();
  end
endmodule : tb_dlb_bridge
